//--- design/du_top.v
/*
 Two-channel UART: host strobe port, per-channel register sets, a
 two-entry transmit buffer, serial transmitter and receiver with
 infrared option, and modem control pins.
 Assumes host pins are asynchronous to CLK and strobes last well over
 three clock periods.
*/
`timescale 1ns/1ps
`default_nettype none
`include "du_regs.vh"
////////////////////////////////////////////////////////////////////////////////
// One channel: registers, transmit buffer, transmitter and receiver
module du_chan #(
	parameter TICK_CYC = `DU_TICK_CYC
) (
	input wire clk,
	input wire rst_n,
	input wire wr_stb,
	input wire rd_done,
	input wire [2:0] addr,
	input wire [7:0] wdata,
	output reg [7:0] rdata,
	input wire rx_in,
	input wire cts_n,
	input wire dsr_n,
	output reg tx_out_r,
	output reg rts_n_r,
	output reg dtr_n_r,
	output reg irq_r,
	output reg tx_room_n_r,
	output wire bcast
);
	localparam RX_IDLE = 2'b00;
	localparam RX_START = 2'b01;
	localparam RX_DATA = 2'b10;
	localparam RX_STOP = 2'b11;
	reg [7:0] ier_r, feature_control_reg_r, efr_r, mcr_r, extended_mode_reg_r, afr_r; // Control registers
	reg [7:0] buf0_r, buf1_r; // Two-entry transmit buffer
	reg [1:0] cnt_r; // Buffer fill level
	reg [7:0] rhr_r; // Received byte
	reg rx_full_r; // Received byte waiting
	reg cts_chg_r; // Sticky clear-send change
	reg cts_old_r; // Last clear-send level
	reg [15:0] div_r; // Tick divider
	wire tick = (div_r == 16'h0000);
	reg tx_busy_r; // Frame in progress
	reg [9:0] tx_sh_r; // Frame shifter, LSB on line
	reg [3:0] tx_bits_r, tx_ph_r; // Bit count and tick phase
	reg [1:0] rx_st_r; // Receiver state
	reg [3:0] rx_ph_r, rx_bits_r;
	reg [7:0] rx_sh_r;
	wire ir = mcr_r[`DU_MCR_IR];
	// Infrared decode: pulses idle low, optional inversion first
	wire rx_bit = ir ? ~(rx_in ^ feature_control_reg_r[`DU_FEATURE_CONTROL_REG_RXINV]) : rx_in;
	wire room = (cnt_r != 2'h2);
	wire push = wr_stb && (addr == `DU_REG_DATA) && room;
	// Auto clear-send holds a new frame back while the line is not clear
	wire cts_ok = ~efr_r[`DU_EFR_ACTS] | ~cts_n;
	wire pop = !tx_busy_r && (cnt_r != 2'h0) && cts_ok;
	wire rhr_take = rd_done && (addr == `DU_REG_DATA);
	wire rx_done = tick && (rx_st_r == RX_STOP) && (rx_ph_r == `DU_BIT_TICKS);
	assign bcast = afr_r[`DU_AFR_BCAST];

	// Read mux, sampled by the top at the read strobe's falling edge
	always @* begin
		case (addr)
			`DU_REG_DATA: rdata = rhr_r;
			`DU_REG_IER: rdata = ier_r;
			`DU_REG_FEATURE_CONTROL_REG: rdata = feature_control_reg_r;
			`DU_REG_EFR: rdata = efr_r;
			`DU_REG_MCR: rdata = mcr_r;
			`DU_REG_LSR: rdata = {1'b0, (cnt_r == 2'h0) & !tx_busy_r, room, 4'h0, rx_full_r};
			`DU_REG_MSR: rdata = {2'b00, ~dsr_n, ~cts_n, 3'b000, cts_chg_r};
			default: rdata = afr_r;
		endcase
	end

	// Register writes; only this channel's set changes
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ier_r <= `DU_REG_RST;
			feature_control_reg_r <= `DU_REG_RST;
			efr_r <= `DU_REG_RST;
			mcr_r <= `DU_REG_RST;
			extended_mode_reg_r <= `DU_REG_RST;
			afr_r <= `DU_REG_RST;
		end else if (wr_stb) begin
			case (addr)
				`DU_REG_IER: ier_r <= wdata;
				`DU_REG_FEATURE_CONTROL_REG: feature_control_reg_r <= wdata;
				`DU_REG_EFR: efr_r <= wdata;
				`DU_REG_MCR: mcr_r <= wdata;
				`DU_REG_EXTENDED_MODE_REG: extended_mode_reg_r <= wdata;
				`DU_REG_AFR: afr_r <= wdata;
				default: ;
			endcase
		end
	end

	// Transmit buffer; writes to a full buffer are dropped
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			buf0_r <= 8'h00;
			buf1_r <= 8'h00;
			cnt_r <= 2'h0;
		end else begin
			if (pop) buf0_r <= buf1_r;
			if (push) begin
				if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) buf0_r <= wdata;
				else buf1_r <= wdata;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	// Tick divider shared by both directions
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) div_r <= 16'h0000;
		else if (tick) div_r <= TICK_CYC[15:0] - 16'h0001;
		else div_r <= div_r - 16'h0001;
	end

	// Transmitter: start, eight data bits, stop
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_r <= 1'b0;
			tx_sh_r <= 10'h3ff;
			tx_bits_r <= 4'h0;
			tx_ph_r <= 4'h0;
		end else if (pop) begin
			tx_busy_r <= 1'b1;
			tx_sh_r <= {1'b1, buf0_r, 1'b0};
			tx_bits_r <= 4'h0;
			tx_ph_r <= 4'h0;
		end else if (tx_busy_r && tick) begin
			tx_ph_r <= tx_ph_r + 4'h1;
			if (tx_ph_r == `DU_BIT_TICKS) begin
				tx_sh_r <= {1'b1, tx_sh_r[9:1]};
				tx_bits_r <= tx_bits_r + 4'h1;
				if (tx_bits_r == 4'h9) tx_busy_r <= 1'b0;
			end
		end
	end

	// Receiver: start bit checked at mid-bit, then centre samples
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_r <= RX_IDLE;
			rx_ph_r <= 4'h0;
			rx_bits_r <= 4'h0;
			rx_sh_r <= 8'h00;
		end else if (tick) begin
			rx_ph_r <= rx_ph_r + 4'h1;
			case (rx_st_r)
				RX_IDLE: begin
					rx_ph_r <= 4'h0;
					if (!rx_bit) rx_st_r <= RX_START; // Line idles high
				end
				RX_START: if (rx_ph_r == `DU_HALF_TICKS) begin
					rx_ph_r <= 4'h0;
					rx_bits_r <= 4'h0;
					rx_st_r <= rx_bit ? RX_IDLE : RX_DATA;
				end
				RX_DATA: if (rx_ph_r == `DU_BIT_TICKS) begin
					rx_sh_r <= {rx_bit, rx_sh_r[7:1]};
					rx_bits_r <= rx_bits_r + 4'h1;
					if (rx_bits_r == 4'h7) rx_st_r <= RX_STOP;
				end
				RX_STOP: if (rx_ph_r == `DU_BIT_TICKS) rx_st_r <= RX_IDLE;
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	// Receive holding flag and clear-send change flag; a set beats a clear
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rhr_r <= 8'h00;
			rx_full_r <= 1'b0;
			cts_chg_r <= 1'b0;
			cts_old_r <= 1'b1;
		end else begin
			cts_old_r <= cts_n;
			if (rx_done) begin
				rhr_r <= rx_sh_r;
				rx_full_r <= 1'b1;
			end else if (rhr_take) rx_full_r <= 1'b0;
			if (cts_old_r != cts_n) cts_chg_r <= 1'b1;
			else if (rd_done && addr == `DU_REG_MSR) cts_chg_r <= 1'b0;
		end
	end

	// Registered line and status outputs
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_out_r <= 1'b1;
			rts_n_r <= 1'b1;
			dtr_n_r <= 1'b1;
			irq_r <= 1'b0;
			tx_room_n_r <= 1'b0;
		end else begin
			if (ir) // Zero bits send a short high pulse, idle low
				tx_out_r <= tx_busy_r & ~tx_sh_r[0] & (tx_ph_r < `DU_IR_PULSE);
			else
				tx_out_r <= tx_sh_r[0];
			if (feature_control_reg_r[`DU_FEATURE_CONTROL_REG_485] && extended_mode_reg_r[`DU_EXTENDED_MODE_REG_485])
				rts_n_r <= ~(tx_busy_r | pop); // Direction follows sending
			else if (efr_r[`DU_EFR_ARTS]) // Relies on host setting request-send first
				rts_n_r <= ~(mcr_r[`DU_MCR_RTS] & ~rx_full_r);
			else
				rts_n_r <= ~mcr_r[`DU_MCR_RTS];
			dtr_n_r <= ~mcr_r[`DU_MCR_DTR];
			irq_r <= (ier_r[`DU_IER_RX] & rx_full_r) |
				(ier_r[`DU_IER_TX] & (cnt_r == 2'h0)) |
				(ier_r[`DU_IER_CTS] & cts_chg_r);
			tx_room_n_r <= ~room;
		end
	end
endmodule // du_chan
////////////////////////////////////////////////////////////////////////////////
// Top: pin synchronisers, strobe decode and the two channels
module du_top #(
	parameter TICK_CYC = `DU_TICK_CYC
) (
	input wire CLK,
	input wire RST_N,
	input wire CS_N,
	input wire CHANNEL_PICK,
	input wire READ_STROBE_N,
	input wire WRITE_STROBE_N,
	input wire [2:0] REG_SELECT,
	input wire [7:0] DATA_IN,
	output reg [7:0] DATA_OUT,
	output reg DATA_OE_N,
	output wire IRQ_CHANNEL_A,
	output wire IRQ_CHANNEL_B,
	output wire TX_ROOM_A_N,
	output wire TX_ROOM_B_N,
	output wire SERIAL_OUT_A,
	output wire SERIAL_OUT_B,
	input wire SERIAL_IN_A,
	input wire SERIAL_IN_B,
	output wire REQUEST_SEND_A_N,
	output wire REQUEST_SEND_B_N,
	input wire CLEAR_SEND_A_N,
	input wire CLEAR_SEND_B_N,
	output wire TERMINAL_READY_A_N,
	output wire TERMINAL_READY_B_N,
	input wire SET_READY_A_N,
	input wire SET_READY_B_N
);
	reg [20:0] s1_r, s2_r, s3_r; // Three-stage pin synchroniser
	reg rd_f_r, wr_f_r; // Filtered strobe levels
	reg [7:0] hd_r; // Data held while write strobe low
	reg [2:0] ha_r; // Select lines held during strobe
	reg hp_r, hc_r; // Channel pick and chip select held
	wire [7:0] rd_a, rd_b;
	wire bc_a, bc_b;
	wire rd_ok = (s2_r[13] == s3_r[13]);
	wire wr_ok = (s2_r[14] == s3_r[14]);
	wire rd_fall = rd_ok && !s3_r[13] && rd_f_r;
	wire rd_rise = rd_ok && s3_r[13] && !rd_f_r;
	wire wr_rise = wr_ok && s3_r[14] && !wr_f_r;
	wire bcast = bc_a | bc_b;
	// A strobe counts only if chip select was low with it
	wire wr_go = wr_rise && !hc_r;
	wire wr_a = wr_go && (hp_r | bcast); // Pick high is channel A
	wire wr_b = wr_go && (!hp_r | bcast);
	wire rd_a_done = rd_rise && !hc_r && hp_r;
	wire rd_b_done = rd_rise && !hc_r && !hp_r;

	// Pin synchroniser; stage one feeds stage two only
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			s1_r <= `DU_SYNC_RST;
			s2_r <= `DU_SYNC_RST;
			s3_r <= `DU_SYNC_RST;
		end else begin
			s1_r <= {SET_READY_B_N, SET_READY_A_N, CLEAR_SEND_B_N, CLEAR_SEND_A_N,
				SERIAL_IN_B, SERIAL_IN_A, WRITE_STROBE_N, READ_STROBE_N, CS_N,
				CHANNEL_PICK, REG_SELECT, DATA_IN};
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Strobe filter and hold of select, address and data while active
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_f_r <= 1'b1;
			wr_f_r <= 1'b1;
			hd_r <= 8'h00;
			ha_r <= 3'h0;
			hp_r <= 1'b0;
			hc_r <= 1'b1;
		end else begin
			if (rd_ok) rd_f_r <= s3_r[13];
			if (wr_ok) wr_f_r <= s3_r[14];
			// Keep the last value seen while a strobe is low
			if (!s3_r[14] || !s3_r[13]) begin
				hd_r <= s3_r[7:0];
				ha_r <= s3_r[10:8];
				hp_r <= s3_r[11];
				hc_r <= s3_r[12];
			end
		end
	end

	// Read data drive: starts at falling edge, released at rising edge
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			DATA_OUT <= 8'h00;
			DATA_OE_N <= 1'b1;
		end else if (rd_fall && !s3_r[12]) begin
			DATA_OUT <= s3_r[11] ? rd_a : rd_b;
			DATA_OE_N <= 1'b0;
		end else if (rd_rise || s3_r[12]) begin
			DATA_OE_N <= 1'b1;
		end
	end

	du_chan #(.TICK_CYC(TICK_CYC)) u_chan_a (
		.clk(CLK), .rst_n(RST_N), .wr_stb(wr_a), .rd_done(rd_a_done),
		.addr(rd_fall ? s3_r[10:8] : ha_r), .wdata(hd_r), .rdata(rd_a),
		.rx_in(s3_r[15]), .cts_n(s3_r[17]), .dsr_n(s3_r[19]),
		.tx_out_r(SERIAL_OUT_A), .rts_n_r(REQUEST_SEND_A_N),
		.dtr_n_r(TERMINAL_READY_A_N), .irq_r(IRQ_CHANNEL_A),
		.tx_room_n_r(TX_ROOM_A_N), .bcast(bc_a)
	);
	du_chan #(.TICK_CYC(TICK_CYC)) u_chan_b (
		.clk(CLK), .rst_n(RST_N), .wr_stb(wr_b), .rd_done(rd_b_done),
		.addr(rd_fall ? s3_r[10:8] : ha_r), .wdata(hd_r), .rdata(rd_b),
		.rx_in(s3_r[16]), .cts_n(s3_r[18]), .dsr_n(s3_r[20]),
		.tx_out_r(SERIAL_OUT_B), .rts_n_r(REQUEST_SEND_B_N),
		.dtr_n_r(TERMINAL_READY_B_N), .irq_r(IRQ_CHANNEL_B),
		.tx_room_n_r(TX_ROOM_B_N), .bcast(bc_b)
	);
endmodule // du_top
`default_nettype wire

//--- design/du_regs.vh
/*
 Constants for the two-channel UART host port and line pins: register
 offsets, field positions, reset values and timing counts.
 Assumes a 20 MHz core clock and an 8-bit strobed host port.
*/
`ifndef DU_REGS_VH
`define DU_REGS_VH
// Register offsets
`define DU_REG_DATA 3'h0
`define DU_REG_IER 3'h1
`define DU_REG_FEATURE_CONTROL_REG 3'h2
`define DU_REG_EFR 3'h3
`define DU_REG_MCR 3'h4
`define DU_REG_LSR 3'h5
`define DU_REG_MSR 3'h6
`define DU_REG_EXTENDED_MODE_REG 3'h6
`define DU_REG_AFR 3'h7
// Field positions
`define DU_MCR_DTR 0
`define DU_MCR_RTS 1
`define DU_MCR_IR 6
`define DU_FEATURE_CONTROL_REG_RXINV 2
`define DU_FEATURE_CONTROL_REG_485 3
`define DU_EXTENDED_MODE_REG_485 3
`define DU_EFR_ARTS 6
`define DU_EFR_ACTS 7
`define DU_IER_RX 0
`define DU_IER_TX 1
`define DU_IER_CTS 7
`define DU_AFR_BCAST 0
// Reset values
`define DU_REG_RST 8'h00
`define DU_SYNC_RST 21'h1ff000
// Timing: 16 ticks per bit; tick length derived from clock and baud rate
`define DU_CLK_HZ 20000000
`define DU_BAUD 115200
`define DU_TICK_CYC (`DU_CLK_HZ / (`DU_BAUD * 16))
`define DU_IR_PULSE 4'h3
`define DU_BIT_TICKS 4'hf
`define DU_HALF_TICKS 4'h7
`endif

//--- sim/du_top_assertions.sv
/*
 Checker for the dual UART host port and line pins.
 Assumes the host drives strobes for at least 5 CLK and data only changes after a write.
*/
`timescale 1ns/1ps
`default_nettype none
module du_top_chk (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic READ_STROBE_N,
	input wire logic WRITE_STROBE_N,
	input wire logic [7:0] DATA_OUT,
	input wire logic DATA_OE_N,
	input wire logic TX_ROOM_A_N,
	input wire logic TX_ROOM_B_N,
	input wire logic SERIAL_OUT_A,
	input wire logic SERIAL_OUT_B,
	input wire logic REQUEST_SEND_A_N,
	input wire logic TERMINAL_READY_A_N,
	input wire logic TERMINAL_READY_B_N
);
	logic [3:0] since_wr_r; // Cycles since write strobe low, saturating
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	////////////////////////////////////////
	// Age of the last write: outputs set by registers may only move shortly after one
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			since_wr_r <= 4'hf;
		end else if (!WRITE_STROBE_N) begin
			since_wr_r <= 4'h0;
		end else if (since_wr_r != 4'hf) begin
			since_wr_r <= since_wr_r + 4'h1;
		end
	end
	////////////////////////////////////////
	sequence s_rd_start;
		$fell(READ_STROBE_N) && !CS_N;
	endsequence
	sequence s_driving;
		!DATA_OE_N && !READ_STROBE_N && !CS_N;
	endsequence
	property p_rst_vals;
		$rose(RST_N) |-> SERIAL_OUT_A && SERIAL_OUT_B && REQUEST_SEND_A_N
			&& TERMINAL_READY_A_N && !TX_ROOM_A_N;
	endproperty
	property p_read_drive;
		s_rd_start |-> ##[2:6] !DATA_OE_N;
	endproperty
	property p_oe_cause;
		$fell(DATA_OE_N) |-> $past(READ_STROBE_N, 2) == 1'b0 && $past(CS_N, 2) == 1'b0;
	endproperty
	property p_read_release;
		$rose(READ_STROBE_N) |-> ##[2:6] DATA_OE_N;
	endproperty
	property p_oe_stands;
		s_driving |=> !DATA_OE_N && $stable(DATA_OUT);
	endproperty
	property p_bus_off;
		CS_N [*8] |-> DATA_OE_N;
	endproperty
	property p_dtr_cause;
		$changed(TERMINAL_READY_A_N) || $changed(TERMINAL_READY_B_N) |-> since_wr_r < 4'ha;
	endproperty
	property p_room_cause;
		$rose(TX_ROOM_A_N) || $rose(TX_ROOM_B_N) |-> since_wr_r < 4'ha;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset pin levels wrong");
	a_read_drive: assert property (p_read_drive) else $error("read not driven");
	a_oe_cause: assert property (p_oe_cause) else $error("bus driven unasked");
	a_read_release: assert property (p_read_release) else $error("bus kept");
	a_oe_stands: assert property (p_oe_stands) else $error("read byte moved");
	a_bus_off: assert property (p_bus_off) else $error("driven while unselected");
	a_dtr_cause: assert property (p_dtr_cause) else $error("ready pin moved");
	a_room_cause: assert property (p_room_cause) else $error("room lost unasked");
endmodule // du_top_chk
bind du_top du_top_chk i_chk (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N),
	.READ_STROBE_N(READ_STROBE_N), .WRITE_STROBE_N(WRITE_STROBE_N), .DATA_OUT(DATA_OUT),
	.DATA_OE_N(DATA_OE_N), .TX_ROOM_A_N(TX_ROOM_A_N), .TX_ROOM_B_N(TX_ROOM_B_N),
	.SERIAL_OUT_A(SERIAL_OUT_A), .SERIAL_OUT_B(SERIAL_OUT_B),
	.REQUEST_SEND_A_N(REQUEST_SEND_A_N), .TERMINAL_READY_A_N(TERMINAL_READY_A_N),
	.TERMINAL_READY_B_N(TERMINAL_READY_B_N));
`default_nettype wire

//--- sim/du_host_model.sv
/*
 Host processor model: strobed byte port tasks and a serial far-end sender.
 Assumes pins are sampled on CLK; all pins change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module du_host_model #(
	parameter BIT_CYC = 32
) (
	input wire logic CLK,
	output logic CS_N,
	output logic CHANNEL_PICK,
	output logic READ_STROBE_N,
	output logic WRITE_STROBE_N,
	output logic [2:0] REG_SELECT,
	output logic [7:0] DATA_IN,
	input wire logic [7:0] DATA_OUT,
	input wire logic DATA_OE_N,
	output logic SERIAL_IN_A
);
	// Deselected host, strobes high; serial line idles high
	initial begin
		CS_N = 1'b1;
		CHANNEL_PICK = 1'b1;
		READ_STROBE_N = 1'b1;
		WRITE_STROBE_N = 1'b1;
		REG_SELECT = 3'h0;
		DATA_IN = 8'h00;
		SERIAL_IN_A = 1'b1;
	end
	// Write: everything set 1 cycle before the strobe and held 6 cycles after it, byte stored on its rise
	task automatic wr(input logic ch, input logic cs, input logic [2:0] a, input logic [7:0] d);
		@(negedge CLK);
		CS_N = cs;
		CHANNEL_PICK = ch;
		REG_SELECT = a;
		DATA_IN = d;
		@(negedge CLK);
		WRITE_STROBE_N = 1'b0;
		repeat (6) @(negedge CLK);
		WRITE_STROBE_N = 1'b1;
		repeat (6) @(negedge CLK);
		CS_N = 1'b1;
		DATA_IN = ~d; // Released bus must not keep the old byte
	endtask
	// Read: byte taken at the last rising edge before the strobe rises
	task automatic rd(input logic ch, input logic cs, input logic [2:0] a,
		output logic [7:0] d, output logic oe_n);
		@(negedge CLK);
		CS_N = cs;
		CHANNEL_PICK = ch;
		REG_SELECT = a;
		@(negedge CLK);
		READ_STROBE_N = 1'b0;
		repeat (6) @(negedge CLK);
		@(posedge CLK);
		d = DATA_OUT;
		oe_n = DATA_OE_N;
		@(negedge CLK);
		READ_STROBE_N = 1'b1;
		repeat (6) @(negedge CLK);
		CS_N = 1'b1;
	endtask
	// Far-end frame: start, 8 bits LSB first, stop; line back high after
	task automatic send_a(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge CLK);
			SERIAL_IN_A = f[i];
			repeat (BIT_CYC - 1) @(negedge CLK);
		end
	endtask
endmodule // du_host_model
`default_nettype wire

//--- sim/dual_uart_host_and_line_pins_test.sv
/*
 Testbench for the dual UART: register access, pins, transmit buffer and receive path.
 Assumes du_top with TICK_CYC 2, so one bit lasts 32 clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module dual_uart_host_and_line_pins_test;
	localparam int BIT = 32; // 16 ticks of 2 cycles
	logic clk, rst_n, cs_n, pick, rd_n, wr_n, oe_n, rx_a, cts_a_n, cts_b_n, dsr_a_n, dsr_b_n;
	logic irq_a, irq_b, room_a, room_b, so_a, so_b, rts_a, rts_b, dtr_a, dtr_b, o;
	logic [2:0] sel;
	logic [7:0] din, dout, d;
	logic [7:0] v [3] = '{8'h5a, 8'h3c, 8'h81};
	int mismatches = 0;
	int n_compared = 0;
	du_top #(.TICK_CYC(2)) i_dut (.CLK(clk), .RST_N(rst_n), .CS_N(cs_n), .CHANNEL_PICK(pick),
		.READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .REG_SELECT(sel), .DATA_IN(din),
		.DATA_OUT(dout), .DATA_OE_N(oe_n), .IRQ_CHANNEL_A(irq_a), .IRQ_CHANNEL_B(irq_b),
		.TX_ROOM_A_N(room_a), .TX_ROOM_B_N(room_b), .SERIAL_OUT_A(so_a), .SERIAL_OUT_B(so_b),
		.SERIAL_IN_A(rx_a), .SERIAL_IN_B(so_b), .REQUEST_SEND_A_N(rts_a),
		.REQUEST_SEND_B_N(rts_b), .CLEAR_SEND_A_N(cts_a_n), .CLEAR_SEND_B_N(cts_b_n),
		.TERMINAL_READY_A_N(dtr_a), .TERMINAL_READY_B_N(dtr_b), .SET_READY_A_N(dsr_a_n),
		.SET_READY_B_N(dsr_b_n));
	du_host_model #(.BIT_CYC(BIT)) i_host (.CLK(clk), .CS_N(cs_n), .CHANNEL_PICK(pick),
		.READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .REG_SELECT(sel), .DATA_IN(din),
		.DATA_OUT(dout), .DATA_OE_N(oe_n), .SERIAL_IN_A(rx_a));
	////////////////////////////////////////
	// 50 ns clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Decode one frame off channel A, sampling mid-bit at falling edges
	task automatic get_frame(output logic [7:0] b);
		int n;
		n = 0;
		while (so_a !== 1'b0 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		repeat (BIT + BIT / 2) @(negedge clk);
		for (int i = 0; i < 8; i++) begin
			b[i] = so_a;
			repeat (BIT) @(negedge clk);
		end
	endtask
	// Hang guard, well above the few thousand cycles the run needs
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
	////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		{cts_a_n, cts_b_n, dsr_a_n, dsr_b_n} = 4'hf;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("idle pins", 8'hfc, {so_a, so_b, rts_a, rts_b, dtr_a, dtr_b, room_a, room_b});
		chk("irq oe", 8'h01, {5'h0, irq_a, irq_b, oe_n});
		i_host.wr(1'b1, 1'b0, 3'h4, 8'h03);
		chk("modem pins", 8'h03, {4'h0, rts_a, dtr_a, rts_b, dtr_b});
		i_host.rd(1'b1, 1'b0, 3'h4, d, o);
		chk("mcr a", 8'h03, d);
		chk("read oe", 8'h00, {7'h0, o});
		i_host.wr(1'b0, 1'b1, 3'h4, 8'hff);
		i_host.rd(1'b0, 1'b0, 3'h4, d, o);
		chk("mcr b", 8'h00, d);
		i_host.rd(1'b0, 1'b1, 3'h4, d, o);
		chk("unselected oe", 8'h01, {7'h0, o});
		i_host.wr(1'b0, 1'b0, 3'h4, 8'h40);
		chk("ir idle", 8'h00, {7'h0, so_b});
		i_host.wr(1'b1, 1'b0, 3'h7, 8'h01);
		i_host.wr(1'b0, 1'b0, 3'h4, 8'h01);
		chk("both dtr", 8'h00, {6'h0, dtr_a, dtr_b});
		i_host.wr(1'b1, 1'b0, 3'h7, 8'h00);
		dsr_a_n = 1'b0;
		i_host.rd(1'b1, 1'b0, 3'h6, d, o);
		chk("status a", 8'h20, d);
		i_host.wr(1'b1, 1'b0, 3'h1, 8'h02);
		chk("irq empty", 8'h01, {7'h0, irq_a});
		i_host.wr(1'b1, 1'b0, 3'h1, 8'h80);
		cts_a_n = 1'b0;
		repeat (8) @(negedge clk);
		chk("irq cts", 8'h01, {7'h0, irq_a});
		i_host.rd(1'b1, 1'b0, 3'h6, d, o);
		chk("cts status", 8'h31, d);
		chk("irq clear", 8'h00, {7'h0, irq_a});
		fork
			begin
				for (int i = 0; i < 3; i++) i_host.wr(1'b1, 1'b0, 3'h0, v[i]);
				chk("room full", 8'h01, {7'h0, room_a});
			end
			for (int i = 0; i < 3; i++) begin
				get_frame(d);
				chk("tx frame", v[i], d);
			end
		join
		repeat (2 * BIT) @(negedge clk);
		i_host.rd(1'b1, 1'b0, 3'h5, d, o);
		chk("line status", 8'h60, d);
		i_host.send_a(8'ha5);
		i_host.rd(1'b1, 1'b0, 3'h0, d, o);
		chk("rx byte", 8'ha5, d);
		// Channel B loops its own line back: request-send first, then auto modes
		i_host.wr(1'b0, 1'b0, 3'h4, 8'h02);
		i_host.wr(1'b0, 1'b0, 3'h3, 8'hc0);
		i_host.wr(1'b0, 1'b0, 3'h0, 8'h96);
		i_host.rd(1'b0, 1'b0, 3'h5, d, o);
		chk("cts hold", 8'h20, d);
		chk("held line", 8'h01, {7'h0, so_b});
		cts_b_n = 1'b0;
		repeat (11 * BIT) @(negedge clk);
		chk("auto rts full", 8'h01, {7'h0, rts_b});
		i_host.rd(1'b0, 1'b0, 3'h0, d, o);
		chk("loop byte", 8'h96, d);
		chk("auto rts free", 8'h00, {7'h0, rts_b});
		// Direction control: request-send low only while a frame is out
		i_host.wr(1'b0, 1'b0, 3'h2, 8'h08);
		i_host.wr(1'b0, 1'b0, 3'h6, 8'h08);
		chk("485 idle", 8'h01, {7'h0, rts_b});
		i_host.wr(1'b0, 1'b0, 3'h0, 8'h3c);
		chk("485 send", 8'h00, {7'h0, rts_b});
		repeat (11 * BIT) @(negedge clk);
		chk("485 done", 8'h01, {7'h0, rts_b});
		i_host.rd(1'b0, 1'b0, 3'h0, d, o);
		chk("loop byte 2", 8'h3c, d);
		// Inversion set before infrared mode, so no false start bit is seen
		i_host.wr(1'b1, 1'b0, 3'h2, 8'h04);
		i_host.wr(1'b1, 1'b0, 3'h4, 8'h40);
		chk("ir idle a", 8'h00, {7'h0, so_a});
		i_host.send_a(8'h5a);
		i_host.rd(1'b1, 1'b0, 3'h0, d, o);
		chk("ir rx byte", 8'h5a, d);
		report_and_stop();
	end
endmodule // dual_uart_host_and_line_pins_test
`default_nettype wire
